/* File: hw/rpx_pkg.sv */
package rpx_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned DM_HALF_50_US = 10000;
  localparam int unsigned DM_HALF_60_US = 8330;
  localparam int unsigned MS_TICK_US    = 1000;
  localparam int unsigned DM_50_CYC     = DM_HALF_50_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned DM_60_CYC     = DM_HALF_60_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned MS_CYC        = MS_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned HOLD_MULT     = 3;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned N_SRC    = 16;
  localparam int unsigned N_RIN    = 32;
  localparam int unsigned N_PAIR   = 32;
  localparam int unsigned ID_WORDS = 5;
  localparam int unsigned N_DM     = 8;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_ONLINE = 12'h008;
  localparam logic [11:0] REG_RIN    = 12'h00c;
  localparam logic [11:0] REG_UPD    = 12'h010;
  localparam logic [11:0] REG_LOCID  = 12'h040;
  localparam logic [11:0] REG_REMID  = 12'h100;
  localparam logic [11:0] REG_REMEND = 12'h300;
  localparam logic [11:0] REG_RINCFG = 12'h400;

  // Fields
  localparam int unsigned CTRL_F60    = 0;
  localparam int unsigned CTRL_DM_EN  = 1;
  localparam int unsigned CTRL_CH2_EN = 2;
  localparam int unsigned CFG_SRC_LSB  = 0;
  localparam int unsigned CFG_PAIR_LSB = 5;
  localparam int unsigned CFG_FB_LSB   = 12;

  // Reset values
  localparam logic [2:0]  CTRL_RST   = 3'h2;
  localparam logic [15:0] UPD_MS_RST = 16'h03e8;

  // DNA pair indices, zero based
  localparam int unsigned DNA_STATUS  = 20;
  localparam int unsigned DNA_MODE    = 26;
  localparam int unsigned DNA_RSVD_LO = 27;

  // Bit pair codes and bus answers
  localparam logic [1:0] PAIR_ON     = 2'h2;
  localparam logic [1:0] PAIR_OFF    = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RPX_FB_ON       = 2'b00,
    RPX_FB_OFF      = 2'b01,
    RPX_FB_LAST_ON  = 2'b10,
    RPX_FB_LAST_OFF = 2'b11
  } rpx_fallback_t;

  typedef enum logic [3:0] {
    RPX_K_NONE   = 4'b0000,
    RPX_K_CTRL   = 4'b0001,
    RPX_K_STATUS = 4'b0010,
    RPX_K_ONLINE = 4'b0011,
    RPX_K_RIN    = 4'b0100,
    RPX_K_UPD    = 4'b0101,
    RPX_K_LOCID  = 4'b0110,
    RPX_K_REMID  = 4'b0111,
    RPX_K_RINCFG = 4'b1000
  } rpx_kind_t;

  typedef struct packed {
    rpx_kind_t   kind;
    logic [3:0]  src;
    logic [2:0]  word;
    logic [4:0]  rin;
  } rpx_dec_t;

endpackage : rpx_pkg

/* File: hw/rpx_top.sv */
`timescale 1ns/100ps

module rpx_top
  import rpx_pkg::*;
#(
  parameter int unsigned MS_CYC_P    = MS_CYC,
  parameter int unsigned DM_50_CYC_P = DM_50_CYC,
  parameter int unsigned DM_60_CYC_P = DM_60_CYC
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // Register bus
  input  wire logic [11:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [11:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Local operands and straps
  input  wire logic          ch2_fitted,
  input  wire logic [31:0]   dna_operand,
  input  wire logic          local_available,
  input  wire logic          local_test_mode,
  input  wire logic [7:0]    dm_out_ch1,
  input  wire logic [7:0]    dm_out_ch2,
  // Direct message transmit
  output logic               dm_tx_ch1_stb,
  output logic [7:0]         dm_tx_ch1_pts,
  output logic               dm_tx_ch2_stb,
  output logic [7:0]         dm_tx_ch2_pts,
  // Message receive
  input  wire logic          rx_valid,
  input  wire logic [159:0]  rx_originator,
  input  wire logic [15:0]   rx_hold_ms,
  input  wire logic [63:0]   rx_dna,
  input  wire logic [63:0]   rx_userst,
  // Message transmit
  output logic               tx_valid,
  output logic [159:0]       tx_originator,
  output logic [17:0]        tx_hold_ms,
  output logic [63:0]        tx_dna,
  // Resolved points
  output logic [31:0]        remote_in,
  output logic [15:0]        src_online
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0]                         ctrl;
    logic [15:0]                        upd_ms;
    logic [ID_WORDS-1:0][31:0]          loc_id;
    logic [N_SRC-1:0][ID_WORDS-1:0][31:0] rem_id;
    logic [N_RIN-1:0][13:0]             rin_cfg;
    logic [N_SRC-1:0][127:0]            src_pairs;
    logic [N_SRC-1:0][15:0]             hold_cnt;
    logic [N_SRC-1:0]                   online;
    logic [N_RIN-1:0]                   rin;
    logic [N_RIN-1:0]                   rin_last;
    logic [N_RIN-1:0]                   rin_known;
    logic [15:0]                        ms_cnt;
    logic                               ms_tick;
    logic [18:0]                        dm_cnt;
    logic                               dm1_stb;
    logic                               dm2_stb;
    logic [7:0]                         dm1_pts;
    logic [7:0]                         dm2_pts;
    logic [15:0]                        upd_cnt;
    logic                               tx_valid;
    logic                               tx_started;
    logic [63:0]                        tx_dna;
    logic [17:0]                        tx_hold;
    logic [11:0]                        awaddr;
    logic                               aw_have;
    logic [31:0]                        wdata;
    logic [3:0]                         wstrb;
    logic                               w_have;
    logic                               awrdy;
    logic                               wrdy;
    logic                               arrdy;
    logic                               bvalid;
    logic [1:0]                         bresp;
    logic                               rvalid;
    logic [31:0]                        rdata;
    logic [1:0]                         rresp;
  } rpx_state_t;

  localparam rpx_state_t RST_STATE = '{ctrl: CTRL_RST, upd_ms: UPD_MS_RST, default: '0};

  rpx_state_t        s;
  rpx_state_t        n;
  logic              rst_meta;
  logic              rst_n;
  logic [N_SRC-1:0]  hit;
  logic [N_RIN-1:0]  live;
  logic [N_RIN-1:0]  sel_bit;
  logic [63:0]       dna_next;
  logic [63:0]       rx_dna_clean;
  rpx_dec_t          wd;
  rpx_dec_t          rd;
  logic [31:0]       wval;
  logic [4:0]        src_f;
  logic [5:0]        pair_f;
  logic [3:0]        sidx;
  logic [1:0]        pv;
  logic              pbit;
  logic              send;

  // ****************************************
  // Functions
  // ****************************************
  function automatic rpx_dec_t rpx_decode(input logic [11:0] a);
    rpx_dec_t    d;
    logic [11:0] off;
    d = '{kind: RPX_K_NONE, default: '0};
    off = a - REG_REMID;
    if (a[1:0] == 2'h0) begin
      if (a == REG_CTRL) d.kind = RPX_K_CTRL;
      else if (a == REG_STATUS) d.kind = RPX_K_STATUS;
      else if (a == REG_ONLINE) d.kind = RPX_K_ONLINE;
      else if (a == REG_RIN) d.kind = RPX_K_RIN;
      else if (a == REG_UPD) d.kind = RPX_K_UPD;
      else if (a >= REG_LOCID && a < REG_LOCID + 12'(4 * ID_WORDS)) begin
        d.kind = RPX_K_LOCID;
        d.word = 3'((a - REG_LOCID) >> 2);
      end else if (a >= REG_REMID && a < REG_REMEND && off[4:2] < 3'(ID_WORDS)) begin
        d.kind = RPX_K_REMID;
        d.src  = off[8:5];
        d.word = off[4:2];
      end else if (a[11:7] == REG_RINCFG[11:7]) begin
        d.kind = RPX_K_RINCFG;
        d.rin  = a[6:2];
      end
    end
    return d;
  endfunction : rpx_decode

  function automatic logic [31:0] rpx_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : rpx_merge

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // Originator filter
  // ****************************************
  // An all-zero entry is unused, so blank identities never capture
  for (genvar k = 0; k < N_SRC; k++) begin : g_hit
    assign hit[k] = (s.rem_id[k] != '0) && (s.rem_id[k] == rx_originator);
  end

  assign rx_dna_clean = {{5{PAIR_OFF}}, rx_dna[2*DNA_RSVD_LO-1:0]};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n         = s;
    n.ms_tick = 1'b0;
    n.dm1_stb = 1'b0;
    n.dm2_stb = 1'b0;
    n.tx_valid = 1'b0;
    wd       = rpx_decode(s.awaddr);
    rd       = rpx_decode(s_axi_araddr);
    wval     = '0;
    dna_next = '0;
    live     = '0;
    sel_bit  = '0;
    src_f    = '0;
    pair_f   = '0;
    sidx     = '0;
    pv       = '0;
    pbit     = 1'b0;
    send     = 1'b0;

    if (s.ms_cnt == 16'(MS_CYC_P - 1)) begin
      n.ms_cnt  = '0;
      n.ms_tick = 1'b1;
    end else begin
      n.ms_cnt = s.ms_cnt + 16'h0001;
    end

    if (s.dm_cnt >= 19'((s.ctrl[CTRL_F60] ? DM_60_CYC_P : DM_50_CYC_P) - 1)) begin
      n.dm_cnt = '0;
      if (s.ctrl[CTRL_DM_EN]) begin
        n.dm1_stb = 1'b1;
        n.dm1_pts = dm_out_ch1;
        if (ch2_fitted && s.ctrl[CTRL_CH2_EN]) begin
          n.dm2_stb = 1'b1;
          n.dm2_pts = dm_out_ch2;
        end
      end
    end else begin
      n.dm_cnt = s.dm_cnt + 19'h00001;
    end

    for (int k = 0; k < N_SRC; k++) begin
      if (rx_valid && hit[k]) begin
        n.src_pairs[k] = {rx_userst, rx_dna_clean};
        n.hold_cnt[k]  = rx_hold_ms;
        n.online[k]    = 1'b1;
      end else if (s.ms_tick && s.online[k]) begin
        if (s.hold_cnt[k] <= 16'h0001) begin
          n.hold_cnt[k] = '0;
          n.online[k]   = 1'b0;
        end else begin
          n.hold_cnt[k] = s.hold_cnt[k] - 16'h0001;
        end
      end
    end

    for (int i = 0; i < N_RIN; i++) begin
      src_f  = s.rin_cfg[i][CFG_SRC_LSB +: 5];
      pair_f = s.rin_cfg[i][CFG_PAIR_LSB +: 6];
      sidx   = 4'(src_f - 5'h01);
      pv     = s.src_pairs[sidx][{pair_f, 1'b0} +: 2];
      sel_bit[i] = (pv == PAIR_ON);
      live[i]    = (src_f != 5'h00) && (src_f <= 5'(N_SRC)) && s.online[sidx];
      if (live[i]) begin
        n.rin[i]       = sel_bit[i];
        n.rin_last[i]  = sel_bit[i];
        n.rin_known[i] = 1'b1;
      end else begin
        unique case (rpx_fallback_t'(s.rin_cfg[i][CFG_FB_LSB +: 2]))
          RPX_FB_ON:       n.rin[i] = 1'b1;
          RPX_FB_OFF:      n.rin[i] = 1'b0;
          RPX_FB_LAST_ON:  n.rin[i] = s.rin_known[i] ? s.rin_last[i] : 1'b1;
          RPX_FB_LAST_OFF: n.rin[i] = s.rin_known[i] ? s.rin_last[i] : 1'b0;
        endcase
      end
    end

    for (int p = 0; p < N_PAIR; p++) begin
      pbit = dna_operand[p];
      if (p == DNA_STATUS) pbit = local_available;
      if (p == DNA_MODE) pbit = local_test_mode;
      if (p >= DNA_RSVD_LO) pbit = 1'b0;
      dna_next[2*p +: 2] = pbit ? PAIR_ON : PAIR_OFF;
    end

    // Sent at startup, on any change and at each upd_ms interval
    if (s.ms_tick) n.upd_cnt = s.upd_cnt + 16'h0001;
    send = !s.tx_started || (dna_next != s.tx_dna) ||
           (s.ms_tick && (s.upd_cnt + 16'h0001 >= s.upd_ms));
    if (send) begin
      n.tx_valid   = 1'b1;
      n.tx_started = 1'b1;
      n.tx_dna     = dna_next;
      n.upd_cnt    = '0;
      n.tx_hold    = 18'(s.upd_ms) * 18'(HOLD_MULT);
    end

    // ****************************************
    // Register bus write
    // ****************************************
    if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (s.awrdy && s_axi_awvalid) begin
      n.aw_have = 1'b1;
      n.awaddr  = s_axi_awaddr;
    end
    if (s.wrdy && s_axi_wvalid) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    // Address seen one cycle before data is decoded from the held copy
    if (s.aw_have && s.w_have) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OKAY;
      unique case (wd.kind)
        RPX_K_CTRL: begin
          wval   = rpx_merge({29'h0, s.ctrl}, s.wdata, s.wstrb);
          n.ctrl = wval[2:0];
          // channel two bit locked when absent
          if (!ch2_fitted) n.ctrl[CTRL_CH2_EN] = 1'b0;
          // rate change restarts pacing, so no slot overshoots the new period
          if (wval[CTRL_F60] != s.ctrl[CTRL_F60]) n.dm_cnt = '0;
        end
        RPX_K_UPD: begin
          wval     = rpx_merge({16'h0, s.upd_ms}, s.wdata, s.wstrb);
          n.upd_ms = wval[15:0];
        end
        RPX_K_LOCID: n.loc_id[wd.word] = rpx_merge(s.loc_id[wd.word], s.wdata, s.wstrb);
        RPX_K_REMID: n.rem_id[wd.src][wd.word] =
                       rpx_merge(s.rem_id[wd.src][wd.word], s.wdata, s.wstrb);
        RPX_K_RINCFG: begin
          wval             = rpx_merge({18'h0, s.rin_cfg[wd.rin]}, s.wdata, s.wstrb);
          n.rin_cfg[wd.rin] = wval[13:0];
        end
        RPX_K_STATUS, RPX_K_ONLINE, RPX_K_RIN: n.bresp = RESP_OKAY;
        RPX_K_NONE: n.bresp = RESP_SLVERR;
        default: n.bresp = RESP_SLVERR;
      endcase
    end

    // ****************************************
    // Register bus read
    // ****************************************
    if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s.arrdy && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = '0;
      unique case (rd.kind)
        RPX_K_CTRL:   n.rdata = {29'h0, s.ctrl & {!ch2_fitted ? 1'b0 : 1'b1, 2'h3}};
        RPX_K_STATUS: n.rdata = {30'h0, s.tx_started, ch2_fitted};
        RPX_K_ONLINE: n.rdata = {16'h0, s.online};
        RPX_K_RIN:    n.rdata = s.rin;
        RPX_K_UPD:    n.rdata = {16'h0, s.upd_ms};
        RPX_K_LOCID:  n.rdata = s.loc_id[rd.word];
        RPX_K_REMID:  n.rdata = s.rem_id[rd.src][rd.word];
        RPX_K_RINCFG: n.rdata = {18'h0, s.rin_cfg[rd.rin]};
        RPX_K_NONE:   n.rresp = RESP_SLVERR;
        default:      n.rresp = RESP_SLVERR;
      endcase
    end

    // Ready flags registered so every bus output comes from a flop
    n.awrdy = !n.aw_have && !n.bvalid;
    n.wrdy  = !n.w_have && !n.bvalid;
    n.arrdy = !n.rvalid;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) s <= RST_STATE;
    else s <= n;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = s.awrdy;
  assign s_axi_wready  = s.wrdy;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arrdy;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign dm_tx_ch1_stb = s.dm1_stb;
  assign dm_tx_ch1_pts = s.dm1_pts;
  assign dm_tx_ch2_stb = s.dm2_stb;
  assign dm_tx_ch2_pts = s.dm2_pts;
  assign tx_valid      = s.tx_valid;
  assign tx_originator = s.loc_id;
  assign tx_hold_ms    = s.tx_hold;
  assign tx_dna        = s.tx_dna;
  assign remote_in     = s.rin;
  assign src_online    = s.online;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_dm_period: assert property (dm_tx_ch1_stb |-> $past(s.dm_cnt) ==
    19'(($past(s.ctrl[CTRL_F60]) ? DM_60_CYC_P : DM_50_CYC_P) - 1))
    else $error("direct message strobe off its half cycle slot");
  a_ch2_absent: assert property (!$past(ch2_fitted) |-> !dm_tx_ch2_stb)
    else $error("channel two sent while not fitted");
  a_tx_origin: assert property (tx_valid |-> tx_originator == s.loc_id && tx_dna[0 +: 2] != 2'h0)
    else $error("sent message lacks local identity");
  a_rx_capture: assert property (rx_valid && hit[0] |=>
    src_online[0] && s.hold_cnt[0] == $past(rx_hold_ms))
    else $error("matching message not captured");
  a_rx_ignore: assert property (rx_valid && hit == '0 |=> $stable(s.src_pairs))
    else $error("unmatched message changed source data");
  a_fb_high: assert property (!live[0] &&
    s.rin_cfg[0][CFG_FB_LSB +: 2] == RPX_FB_ON |=> remote_in[0])
    else $error("fixed high fallback not applied");
  a_fb_low: assert property (!live[0] &&
    s.rin_cfg[0][CFG_FB_LSB +: 2] == RPX_FB_OFF |=> !remote_in[0])
    else $error("fixed low fallback not applied");
  a_hold_last: assert property (!live[0] && s.rin_cfg[0][CFG_FB_LSB + 1] &&
    s.rin_known[0] |=> remote_in[0] == $past(s.rin_last[0]))
    else $error("held input lost its last state");
  a_follow_live: assert property (live[0] |=> remote_in[0] == $past(sel_bit[0]))
    else $error("live input not following source");
  a_hold_expire: assert property (s.online[0] && s.ms_tick &&
    s.hold_cnt[0] <= 16'h0001 && !(rx_valid && hit[0]) |=> !src_online[0])
    else $error("source stayed online after hold expiry");
  a_rsvd_zero: assert property (tx_valid |-> tx_dna[63:54] == {5{PAIR_OFF}})
    else $error("reserved pairs not sent as zero");

endmodule : rpx_top

/* File: bench/rpx_peer.sv */
`timescale 1ns/100ps
module rpx_peer (
  // Bench side
  input  wire logic         core_clk,
  input  wire logic         send,
  input  wire logic [159:0] id,
  input  wire logic [63:0]  dna,
  input  wire logic [15:0]  upd_ms,
  // Message lines
  output logic              rx_valid,
  output logic [159:0]      rx_originator,
  output logic [15:0]       rx_hold_ms,
  output logic [63:0]       rx_dna,
  output logic [63:0]       rx_userst
);
  initial begin
    rx_valid      = 1'b0;
    rx_originator = '0;
    rx_hold_ms    = '0;
    rx_dna        = '0;
    rx_userst     = '0;
  end
  // Fields flip between frames so stale data never looks valid
  always @(posedge core_clk) begin
    rx_valid      <= send;
    rx_originator <= send ? id : ~rx_originator;
    rx_hold_ms    <= send ? 16'(3 * upd_ms) : ~rx_hold_ms;
    rx_dna        <= send ? dna : ~rx_dna;
    // UserSt carries the inverse of DNA so the two halves never alias
    rx_userst     <= send ? ~dna : ~rx_userst;
  end
endmodule : rpx_peer

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import rpx_pkg::*;
  logic core_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ch2_fitted, local_available, local_test_mode, dm_tx_ch1_stb, dm_tx_ch2_stb;
  logic rx_valid, tx_valid, send;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [3:0]   s_axi_wstrb;
  logic [7:0]   dm_out_ch1, dm_out_ch2, dm_tx_ch1_pts, dm_tx_ch2_pts;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0]  rx_hold_ms, src_online, upd_ms;
  logic [17:0]  tx_hold_ms;
  logic [31:0]  s_axi_wdata, s_axi_rdata, dna_operand, remote_in;
  logic [63:0]  rx_dna, rx_userst, tx_dna, dna;
  logic [159:0] rx_originator, tx_originator, id;
  int           bad_count, compares;

  rpx_top #(.MS_CYC_P(8), .DM_50_CYC_P(20), .DM_60_CYC_P(16)) i_dut (.*);
  rpx_peer i_peer (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic hang(input logic ok);
    if (ok !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : hang

  // Both request channels stay up until their own ready is seen at an edge
  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic ka, kw, kr, kd;
    int   n;
    kd = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_bready  <= w;
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    for (n = 0; n < 99 && !kd; n++) begin
      @(negedge core_clk);
      kd = w ? s_axi_bvalid : s_axi_rvalid;
      r  = w ? s_axi_bresp : s_axi_rresp;
      q  = s_axi_rdata;
      ka = s_axi_awready;
      kw = s_axi_wready;
      kr = s_axi_arready;
      @(posedge core_clk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
      if (kr) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    hang(kd);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, a, d, q, r);
  endtask : wr

  task automatic msg(input logic [159:0] i, input logic [1:0] p);
    @(posedge core_clk);
    send <= 1'b1;
    id   <= i;
    dna  <= {32{p}};
    @(posedge core_clk);
    send <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : msg

  task automatic gap(output int g);
    int n;
    for (n = 0; n < 99 && !dm_tx_ch1_stb; n++) @(negedge core_clk);
    @(negedge core_clk);
    for (g = 1; g < 99 && !dm_tx_ch1_stb; g++) @(negedge core_clk);
    hang(n < 99 && g < 99);
  endtask : gap

  task automatic t_rx();
    for (int i = 0; i < 4; i++)
      wr(REG_RINCFG + 12'(4 * i), 32'(1 + (5 << CFG_PAIR_LSB) + (i << CFG_FB_LSB)));
    // UserSt-6 from source 1, fixed low fallback
    wr(REG_RINCFG + 12'h010, 32'(1 + (37 << CFG_PAIR_LSB) + (1 << CFG_FB_LSB)));
    wr(REG_UPD, 32'h1);
    @(negedge core_clk);
    `CHK(remote_in[4:0], 5'h05) // startup state
    wr(REG_REMID, 32'h0000_4142);
    msg(160'h4143, 2'b10);
    `CHK({src_online[0], remote_in[4:0]}, 6'h05) // foreign sender
    msg(160'h4142, 2'b01);
    `CHK({src_online[0], remote_in[4:0]}, 6'h30) // source taken
    msg(160'h4142, 2'b10);
    `CHK(remote_in[4:0], 5'h0f) // follows messages
    repeat (10) @(negedge core_clk);
    `CHK(src_online[0], 1'b1) // hold still running
    repeat (16) @(negedge core_clk);
    `CHK({src_online[0], remote_in[4:0]}, 6'h0d) // frozen
    $display("receive test done");
  endtask : t_rx

  task automatic t_tx();
    int          n;
    logic [31:0] v;
    logic [63:0] e;
    wr(REG_LOCID, 32'h1234_5678);
    for (int k = 0; k < 2; k++) begin
      v = k ? 32'ha5c3_0f96 : 32'h5a3c_f069;
      @(posedge core_clk);
      dna_operand     <= v;
      local_available <= k[0];
      local_test_mode <= !k[0];
      repeat (2) @(negedge core_clk);
      for (n = 0; n < 99 && !tx_valid; n++) @(negedge core_clk);
      hang(n < 99);
      v[DNA_STATUS]     = k[0];
      v[DNA_MODE]       = !k[0];
      v[31:DNA_RSVD_LO] = '0;
      for (int p = 0; p < 32; p++) e[2*p +: 2] = v[p] ? PAIR_ON : PAIR_OFF;
      `CHK(tx_dna, e) // coded pairs
      `CHK(tx_hold_ms, 18'd3) // advertised hold
    end
    `CHK(tx_originator[31:0], 32'h1234_5678) // sender name
    $display("transmit test done");
  endtask : t_tx

  task automatic t_dm();
    int          g;
    logic [31:0] q;
    logic [1:0]  r;
    gap(g);
    `CHK(g, 20) // 50 Hz spacing
    `CHK(dm_tx_ch1_pts, 8'h5a) // channel one points
    wr(REG_CTRL, 32'h7);
    gap(g);
    gap(g);
    `CHK(g, 16) // 60 Hz spacing
    for (g = 0; g < 40 && !dm_tx_ch2_stb; g++) @(negedge core_clk);
    `CHK(dm_tx_ch2_pts, 8'hc3) // channel two points
    bus(1'b0, REG_STATUS, '0, q, r);
    `CHK(q[0], 1'b1) // second channel fitted
    bus(1'b0, 12'hffc, '0, q, r);
    `CHK(r, RESP_SLVERR)
    ch2_fitted <= 1'b0;
    @(negedge core_clk);
    gap(g);
    `CHK(dm_tx_ch2_stb, 1'b0) // no channel two when absent
    bus(1'b0, REG_CTRL, '0, q, r);
    `CHK(q[2:0], 3'h3) // channel two setting hidden
    $display("direct test done");
  endtask : t_dm

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, send} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, dna_operand, id, dna} = '0;
    {local_available, local_test_mode, reset_n, bad_count, compares} = '0;
    ch2_fitted  = 1'b1;
    s_axi_wstrb = 4'hf;
    upd_ms      = 16'h1;
    dm_out_ch1  = 8'h5a;
    dm_out_ch2  = 8'hc3;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_rx();
    t_tx();
    t_dm();
    tally_and_finish();
  end
endmodule : tb_top
